/* File: spsq_pkg.sv */
package spsq_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned RAIL_GAP_US = 100;
  localparam int unsigned RST_HOLD_MS = 1;
  localparam int unsigned INIT_REF_CLKS = 150000;
  localparam int unsigned PLL_LOCK_MS = 1;
  localparam int unsigned OFF_WAIT_MS = 100;
  localparam int unsigned RAIL_GAP_CYC = RAIL_GAP_US * CLK_MHZ;
  localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_MS * 1000 * CLK_MHZ;
  localparam int unsigned OFF_WAIT_CYC = OFF_WAIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned REF_HALF_CYC = 5;
  localparam int unsigned TWI_QTR_CYC = 156;

  // ----------------------------------------
  // Device registers
  // ----------------------------------------
  localparam logic [15:0] RUN_CTRL_ADDR = 16'h301A;
  localparam int unsigned RUN_STREAM_BIT = 2;
  localparam logic [15:0] RUN_CTRL_BASE = 16'h0010;
  localparam logic [6:0] TWI_DEV_ADDR = 7'h10;
  localparam int unsigned TWI_FRAME_BYTES = 5;

  // ----------------------------------------
  // Supply rails, in power-down order
  // ----------------------------------------
  localparam int unsigned NUM_RAILS = 5;
  typedef struct packed {
    logic serial_tx_supply;
    logic core_supply;
    logic io_supply;
    logic analog_pix_supply;
    logic pll_supply;
  } spsq_rails_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } spsq_wr_s;

  // ----------------------------------------
  // State machines
  // ----------------------------------------
  typedef enum logic [12:0] {
    ST_DISCHARGE = 13'h0001, ST_IDLE = 13'h0002, ST_RAIL_UP = 13'h0004,
    ST_RST_HOLD = 13'h0008, ST_INIT = 13'h0010, ST_CONFIG = 13'h0020,
    ST_LOCK = 13'h0040, ST_RUN_ON = 13'h0080, ST_STREAMING = 13'h0100,
    ST_RUN_OFF = 13'h0200, ST_STANDBY = 13'h0400, ST_RAIL_DOWN = 13'h0800,
    ST_SPARE = 13'h1000
  } spsq_state_e;

  typedef enum logic [3:0] {
    TW_IDLE = 4'h1, TW_START = 4'h2, TW_BITS = 4'h4, TW_STOP = 4'h8
  } spsq_twi_e;

  // Delay-line steps that give a poor eye
  function automatic logic dly_bad(input logic [2:0] clk_dly, input logic [2:0] dat_dly);
    dly_bad = (clk_dly == 3'h6) || (clk_dly == 3'h7) ||
              (dat_dly == 3'h3) || (dat_dly == 3'h5) || (dat_dly == 3'h7);
  endfunction

endpackage

/* File: spsq_twi_writer.sv */
`timescale 1ns/10ps
module spsq_twi_writer #(
  parameter int unsigned QTR_CYC = spsq_pkg::TWI_QTR_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_req,
  input wire spsq_pkg::spsq_wr_s i_wr,
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe
);
  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  spsq_pkg::spsq_twi_e st_r;
  logic [15:0] qcnt_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [2:0] byte_r;
  logic [39:0] frame_r;
  logic scl_r;
  logic sda_r;
  logic tick;

  assign tick = (qcnt_r == 16'(QTR_CYC - 1));
  assign o_busy = (st_r != spsq_pkg::TW_IDLE);
  // Open drain: drive low only, release to let the pull-up win
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe = ~scl_r;
  assign o_sda_oe = ~sda_r;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      qcnt_r <= 16'h0000;
    end else if (st_r == spsq_pkg::TW_IDLE || tick) begin
      qcnt_r <= 16'h0000;
    end else begin
      qcnt_r <= qcnt_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= spsq_pkg::TW_IDLE;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      byte_r <= 3'h0;
      frame_r <= 40'h00_0000_0000;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      o_done <= 1'b0;
      o_nack <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (st_r)
        spsq_pkg::TW_IDLE: begin
          if (i_req) begin
            frame_r <= {spsq_pkg::TWI_DEV_ADDR, 1'b0, i_wr.addr, i_wr.data};
            o_nack <= 1'b0;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            byte_r <= 3'h0;
            st_r <= spsq_pkg::TW_START;
          end
        end
        spsq_pkg::TW_START: begin
          if (tick) begin
            if (ph_r == 2'h0) begin
              sda_r <= 1'b0;
              ph_r <= 2'h1;
            end else begin
              scl_r <= 1'b0;
              ph_r <= 2'h0;
              st_r <= spsq_pkg::TW_BITS;
            end
          end
        end
        spsq_pkg::TW_BITS: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_r <= (bit_r == 4'h8) ? 1'b1 : frame_r[39];
              2'h1: scl_r <= 1'b1;
              2'h2: begin
                // Clock stretching is not honoured; a slave holding SCL is not expected
                if (bit_r == 4'h8 && i_sda) begin
                  o_nack <= 1'b1;
                end
              end
              default: begin
                scl_r <= 1'b0;
                if (bit_r == 4'h8) begin
                  bit_r <= 4'h0;
                  byte_r <= byte_r + 3'h1;
                  if (byte_r == 3'(spsq_pkg::TWI_FRAME_BYTES - 1)) begin
                    st_r <= spsq_pkg::TW_STOP;
                  end
                end else begin
                  bit_r <= bit_r + 4'h1;
                  frame_r <= {frame_r[38:0], 1'b0};
                end
              end
            endcase
          end
        end
        spsq_pkg::TW_STOP: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_r <= 1'b0;
              2'h1: scl_r <= 1'b1;
              2'h2: sda_r <= 1'b1;
              default: begin
                o_done <= 1'b1;
                st_r <= spsq_pkg::TW_IDLE;
              end
            endcase
          end
        end
        default: st_r <= spsq_pkg::TW_IDLE;
      endcase
    end
  end

endmodule

/* File: spsq_host_seq.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Rails up in order pll, analog+pixel, io, core, serial-tx, 100 us apart.
// - The pll rail is never enabled after any other rail.
// - Reference clock starts only after the last rail has had its settle gap.
// - Hard reset held low at least 1 ms after rails have settled.
// - Sensor needs 150000 reference clocks after reset; host waits that long.
// - Configuration writes are accepted only in the configuration window.
// - Wait 1 ms for the sensor multiplier lock before streaming.
// - Streaming starts by writing run control bit 2 to one, last step.
// - Streaming is stopped by writing bit 2 to zero before rails drop.
// - Rails down in order serial-tx, core, io, analog+pixel, pll last.
// - At least 100 ms after power-down before the next power-up.
// - Clock-lane delay steps 6 and 7 are refused.
// - Data-lane delay steps 3, 5 and 7 are refused.
module spsq_host_seq #(
  parameter int unsigned RAIL_GAP_CYC = spsq_pkg::RAIL_GAP_CYC,
  parameter int unsigned RST_HOLD_CYC = spsq_pkg::RST_HOLD_CYC,
  parameter int unsigned INIT_REF_CLKS = spsq_pkg::INIT_REF_CLKS,
  parameter int unsigned PLL_LOCK_CYC = spsq_pkg::PLL_LOCK_CYC,
  parameter int unsigned OFF_WAIT_CYC = spsq_pkg::OFF_WAIT_CYC,
  parameter int unsigned REF_HALF_CYC = spsq_pkg::REF_HALF_CYC,
  parameter int unsigned TWI_QTR_CYC = spsq_pkg::TWI_QTR_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_power_up,
  input wire logic i_power_down,
  input wire logic i_cfg_valid,
  input wire spsq_pkg::spsq_wr_s i_cfg_wr,
  output logic o_cfg_ready,
  input wire logic i_cfg_done,
  input wire logic [2:0] i_clk_dly,
  input wire logic [2:0] i_data_dly,
  input wire logic i_standby_seen,
  output logic o_dly_bad,
  output logic o_streaming,
  output logic o_powered_off,
  output logic o_nack,
  output spsq_pkg::spsq_rails_s o_rails,
  output logic o_ref_clk,
  output logic o_reset_b,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  spsq_pkg::spsq_state_e st_r;
  spsq_pkg::spsq_state_e st_nxt;
  logic [31:0] timer_r;
  logic [31:0] tgt;
  logic expire;
  logic [2:0] rail_idx_r;
  logic [4:0] rails_r;
  logic [15:0] div_r;
  logic ref_r;
  logic ref_en;
  logic ref_tick;
  logic sent_r;
  logic twi_req;
  logic twi_busy;
  logic twi_done;
  logic dly_bad_now;
  spsq_pkg::spsq_wr_s twi_wr;

  assign dly_bad_now = spsq_pkg::dly_bad(i_clk_dly, i_data_dly);

  // ----------------------------------------
  // Reference clock divider
  // ----------------------------------------
  assign ref_en = (st_r == spsq_pkg::ST_RST_HOLD) || (st_r == spsq_pkg::ST_INIT) ||
                  (st_r == spsq_pkg::ST_CONFIG) || (st_r == spsq_pkg::ST_LOCK) ||
                  (st_r == spsq_pkg::ST_RUN_ON) || (st_r == spsq_pkg::ST_STREAMING) ||
                  (st_r == spsq_pkg::ST_RUN_OFF) || (st_r == spsq_pkg::ST_STANDBY);
  assign ref_tick = ref_en && !ref_r && (div_r == 16'(REF_HALF_CYC - 1));

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_r <= 16'h0000;
      ref_r <= 1'b0;
    end else if (!ref_en) begin
      div_r <= 16'h0000;
      ref_r <= 1'b0;
    end else if (div_r == 16'(REF_HALF_CYC - 1)) begin
      div_r <= 16'h0000;
      ref_r <= ~ref_r;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  assign o_ref_clk = ref_r;

  // ----------------------------------------
  // Interval timer
  // ----------------------------------------
  // One shared counter; each timed state loads its own target, so intervals never overlap
  always_comb begin
    case (st_r)
      spsq_pkg::ST_DISCHARGE: tgt = 32'(OFF_WAIT_CYC);
      spsq_pkg::ST_RAIL_UP: tgt = 32'(RAIL_GAP_CYC);
      spsq_pkg::ST_RST_HOLD: tgt = 32'(RST_HOLD_CYC);
      spsq_pkg::ST_INIT: tgt = 32'(INIT_REF_CLKS);
      spsq_pkg::ST_LOCK: tgt = 32'(PLL_LOCK_CYC);
      spsq_pkg::ST_RAIL_DOWN: tgt = 32'(RAIL_GAP_CYC);
      default: tgt = 32'h0000_0001;
    endcase
  end

  // Initialisation is counted in reference clock rising edges, not core cycles
  assign expire = (timer_r >= tgt - 32'h0000_0001) &&
                  ((st_r != spsq_pkg::ST_INIT) || ref_tick);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer_r <= 32'h0000_0000;
    end else if (st_nxt != st_r || expire) begin
      timer_r <= 32'h0000_0000;
    end else if (st_r != spsq_pkg::ST_INIT || ref_tick) begin
      timer_r <= timer_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      spsq_pkg::ST_DISCHARGE: if (expire) st_nxt = spsq_pkg::ST_IDLE;
      spsq_pkg::ST_IDLE: if (i_power_up) st_nxt = spsq_pkg::ST_RAIL_UP;
      spsq_pkg::ST_RAIL_UP: begin
        if (expire && rail_idx_r == 3'(spsq_pkg::NUM_RAILS)) st_nxt = spsq_pkg::ST_RST_HOLD;
      end
      spsq_pkg::ST_RST_HOLD: if (expire) st_nxt = spsq_pkg::ST_INIT;
      spsq_pkg::ST_INIT: if (expire) st_nxt = spsq_pkg::ST_CONFIG;
      spsq_pkg::ST_CONFIG: begin
        if (i_power_down && !twi_busy) begin
          st_nxt = spsq_pkg::ST_RAIL_DOWN;
        end else if (i_cfg_done && !twi_busy && !twi_req &&
                     !dly_bad_now) begin
          st_nxt = spsq_pkg::ST_LOCK;
        end
      end
      spsq_pkg::ST_LOCK: if (expire) st_nxt = spsq_pkg::ST_RUN_ON;
      spsq_pkg::ST_RUN_ON: if (twi_done) st_nxt = spsq_pkg::ST_STREAMING;
      spsq_pkg::ST_STREAMING: if (i_power_down) st_nxt = spsq_pkg::ST_RUN_OFF;
      spsq_pkg::ST_RUN_OFF: if (twi_done) st_nxt = spsq_pkg::ST_STANDBY;
      spsq_pkg::ST_STANDBY: if (i_standby_seen) st_nxt = spsq_pkg::ST_RAIL_DOWN;
      spsq_pkg::ST_RAIL_DOWN: begin
        if (expire && rail_idx_r == 3'h0) st_nxt = spsq_pkg::ST_DISCHARGE;
      end
      default: st_nxt = spsq_pkg::ST_DISCHARGE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= spsq_pkg::ST_DISCHARGE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Supply rails
  // ----------------------------------------
  // Bit 0 is the pll rail, so stepping up from index 0 and down from the top
  // gives the pll rail first on and last off
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rails_r <= 5'h00;
      rail_idx_r <= 3'h0;
    end else if (st_r == spsq_pkg::ST_IDLE && i_power_up) begin
      rails_r <= 5'h01;
      rail_idx_r <= 3'h1;
    end else if (st_r == spsq_pkg::ST_RAIL_UP && expire &&
                 rail_idx_r != 3'(spsq_pkg::NUM_RAILS)) begin
      rails_r[rail_idx_r] <= 1'b1;
      rail_idx_r <= rail_idx_r + 3'h1;
    end else if (st_r == spsq_pkg::ST_RAIL_DOWN && expire && rail_idx_r != 3'h0) begin
      rails_r[rail_idx_r - 3'h1] <= 1'b0;
      rail_idx_r <= rail_idx_r - 3'h1;
    end
  end

  assign o_rails = rails_r;

  // ----------------------------------------
  // Reset pin
  // ----------------------------------------
  // Pixel pins float while this is low; the receiver must not sample them then
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reset_b <= 1'b0;
    end else begin
      o_reset_b <= (st_nxt == spsq_pkg::ST_INIT) || (st_nxt == spsq_pkg::ST_CONFIG) ||
                   (st_nxt == spsq_pkg::ST_LOCK) || (st_nxt == spsq_pkg::ST_RUN_ON) ||
                   (st_nxt == spsq_pkg::ST_STREAMING) || (st_nxt == spsq_pkg::ST_RUN_OFF) ||
                   (st_nxt == spsq_pkg::ST_STANDBY);
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sent_r <= 1'b0;
    end else if (st_nxt != st_r) begin
      sent_r <= 1'b0;
    end else if (twi_req) begin
      sent_r <= 1'b1;
    end
  end

  // Writes are only ever issued from the configuration window or the two run states
  assign o_cfg_ready = (st_r == spsq_pkg::ST_CONFIG) && !twi_busy &&
                       !i_power_down;

  always_comb begin
    twi_req = 1'b0;
    twi_wr = i_cfg_wr;
    if (st_r == spsq_pkg::ST_RUN_ON || st_r == spsq_pkg::ST_RUN_OFF) begin
      twi_req = !sent_r && !twi_busy;
      twi_wr.addr = spsq_pkg::RUN_CTRL_ADDR;
      twi_wr.data = spsq_pkg::RUN_CTRL_BASE;
      twi_wr.data[spsq_pkg::RUN_STREAM_BIT] = (st_r == spsq_pkg::ST_RUN_ON);
    end else if (o_cfg_ready && i_cfg_valid) begin
      twi_req = 1'b1;
    end
  end

  spsq_twi_writer #(
    .QTR_CYC(TWI_QTR_CYC)
  ) u_twi (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_req(twi_req),
    .i_wr(twi_wr),
    .o_busy(twi_busy),
    .o_done(twi_done),
    .o_nack(o_nack),
    .i_scl(i_scl),
    .o_scl(o_scl),
    .o_scl_oe(o_scl_oe),
    .i_sda(i_sda),
    .o_sda(o_sda),
    .o_sda_oe(o_sda_oe)
  );

  // ----------------------------------------
  // Status
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dly_bad <= 1'b0;
      o_streaming <= 1'b0;
      o_powered_off <= 1'b0;
    end else begin
      o_dly_bad <= dly_bad_now;
      o_streaming <= (st_nxt == spsq_pkg::ST_STREAMING);
      o_powered_off <= (st_nxt == spsq_pkg::ST_IDLE);
    end
  end

endmodule

/* File: spsq_host_seq_props.sv */
`timescale 1ns/10ps
module spsq_host_seq_props #(
  parameter int unsigned RAIL_GAP_CYC = 4,
  parameter int unsigned RST_HOLD_CYC = 8,
  parameter int unsigned INIT_REF_CLKS = 5,
  parameter int unsigned PLL_LOCK_CYC = 6,
  parameter int unsigned OFF_WAIT_CYC = 10
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [2:0] i_clk_dly,
  input wire logic [2:0] i_data_dly,
  input wire logic o_cfg_ready,
  input wire logic o_dly_bad,
  input wire logic o_streaming,
  input wire spsq_pkg::spsq_rails_s o_rails,
  input wire logic o_ref_clk,
  input wire logic o_reset_b,
  input wire logic o_scl_oe,
  input wire logic o_sda_oe
);
  // ----
  // Helper counts
  // ----
  int hold_cnt;
  int ref_rises;
  int nrdy_cnt;
  int off_cnt;
  logic ref_q;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_cnt <= 0;
      ref_rises <= 0;
      nrdy_cnt <= 0;
      off_cnt <= 0;
      ref_q <= 1'b0;
    end else begin
      ref_q <= o_ref_clk;
      hold_cnt <= (o_rails == 5'h1F && !o_reset_b) ? hold_cnt + 1 : 0;
      nrdy_cnt <= o_cfg_ready ? 0 : nrdy_cnt + 1;
      off_cnt <= (o_rails == 5'h00) ? off_cnt + 1 : 0;
      if (!o_reset_b) ref_rises <= 0;
      else if (o_ref_clk && !ref_q) ref_rises <= ref_rises + 1;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  a_pll_first: assert property ((|o_rails) |-> o_rails.pll_supply)
    else $error("rail up without pll rail");
  a_rail_shape: assert property (
    o_rails inside {5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F})
    else $error("rails out of order");
  a_rail_gap: assert property ($changed(o_rails) |=> $stable(o_rails) [*3])
    else $error("rail steps too close");
  a_clk_late: assert property ($rose(o_rails.serial_tx_supply) |-> !o_ref_clk [*3])
    else $error("ref clock before last rail settled");
  a_clk_rails: assert property (o_ref_clk |-> o_rails == 5'h1F)
    else $error("ref clock with rails missing");
  // Sampling edges blur the start of the hold by a cycle or two
  a_reset_hold: assert property (
    $rose(o_reset_b) |-> hold_cnt >= RST_HOLD_CYC + RAIL_GAP_CYC - 2)
    else $error("hard reset released early");
  a_quiet_init: assert property (
    (!o_reset_b || ref_rises + 1 < INIT_REF_CLKS) |-> !o_sda_oe && !o_scl_oe)
    else $error("serial traffic during reset or init");
  a_ready_gate: assert property (
    o_cfg_ready |-> o_reset_b && ref_rises + 1 >= INIT_REF_CLKS && !o_streaming)
    else $error("config offered outside window");
  a_lock_wait: assert property ($rose(o_streaming) |-> nrdy_cnt >= PLL_LOCK_CYC)
    else $error("stream before lock wait");
  a_stop_first: assert property ($fell(o_rails.serial_tx_supply) |-> !o_streaming)
    else $error("rail off while streaming");
  a_off_wait: assert property ($rose(o_rails.pll_supply) |-> off_cnt >= OFF_WAIT_CYC)
    else $error("power up before discharge");
  a_dly_flag: assert property (
    1'b1 |=> o_dly_bad == $past((i_clk_dly[2] && i_clk_dly[1]) ||
                                (i_data_dly[0] && i_data_dly != 3'h1)))
    else $error("delay flag wrong");
endmodule

/* File: spsq_sensor_model.sv */
`timescale 1ns/10ps
module spsq_sensor_model #(
  parameter int unsigned INIT_CLKS = 5
) (
  input wire spsq_pkg::spsq_rails_s i_rails,
  input wire logic i_reset_b,
  input wire logic i_ref_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_nack_mode,
  output logic o_sda_oe,
  output logic o_pix_oe,
  output logic o_standby,
  output logic [15:0] o_run_ctrl,
  output spsq_pkg::spsq_wr_s o_last_wr,
  output int o_early
);
  // ----
  // Power, init and rows
  // ----
  int ref_cnt;
  int bits;
  int nbytes;
  logic [7:0] shift;
  logic [39:0] frame;
  logic [2:0] row;
  logic stream_r;
  wire alive = (i_rails == 5'h1F) && i_reset_b;
  wire init_done = ref_cnt >= INIT_CLKS;
  assign o_pix_oe = alive && init_done;
  assign o_standby = init_done && !stream_r;
  initial begin
    o_sda_oe = 1'b0;
    o_early = 0;
    o_last_wr = '0;
  end
  always @(posedge i_ref_clk or negedge alive) begin
    if (!alive) begin
      ref_cnt <= 0;
      row <= 3'h0;
      stream_r <= 1'b0;
    end else begin
      ref_cnt <= init_done ? ref_cnt : ref_cnt + 1;
      row <= row + 3'h1;
      // Mode changes only at a row end, so a stop lingers up to 8 ref clocks
      if (row == 3'h7) stream_r <= o_run_ctrl[2];
    end
  end
  // ----
  // Two-wire slave
  // ----
  always @(negedge i_sda) begin
    if (i_scl) begin
      bits = 0;
      nbytes = 0;
      if (!init_done) o_early++;
    end
  end
  always @(posedge i_scl) begin
    if (bits < 8) shift = {shift[6:0], i_sda};
    bits++;
  end
  always @(negedge i_scl) begin
    if (bits == 8) begin
      o_sda_oe = alive && !i_nack_mode;
      frame = {frame[31:0], shift};
      nbytes++;
    end else if (bits == 9) begin
      o_sda_oe = 1'b0;
      bits = 0;
    end
  end
  // Register contents are lost with the rails or the hard reset
  always @(posedge i_sda or negedge alive) begin
    if (!alive) begin
      o_run_ctrl = 16'h0000;
    end else if (i_scl && nbytes == 5 && frame[39:32] == 8'h20) begin
      o_last_wr = frame[31:0];
      if (frame[31:16] == 16'h301A) o_run_ctrl = frame[15:0];
    end
  end
endmodule

/* File: spsq_host_seq_bench.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module spsq_host_seq_bench;
  localparam int unsigned GAP = 4;
  localparam int unsigned HOLD = 8;
  localparam int unsigned INIT = 5;
  localparam int unsigned LOCK = 6;
  localparam int unsigned OFFW = 10;
  logic clk = 1'b0, rst_b = 1'b0, pwr_up = 1'b0, pwr_dn = 1'b0;
  logic cfg_valid = 1'b0, cfg_done = 1'b0, nack_mode = 1'b0;
  logic [2:0] clk_dly = 3'h1, data_dly = 3'h1;
  spsq_pkg::spsq_wr_s cfg_wr = '0, last_wr;
  spsq_pkg::spsq_rails_s rails;
  logic [15:0] run_ctrl;
  logic cfg_ready, dly_bad, streaming, powered_off, nack, ref_clk, reset_b;
  logic scl_oe, sda_oe, mdl_oe, standby, pix_oe, scl_drv, sda_drv;
  int early, n, miscompares = 0, num_checks = 0;
  wire scl = ~scl_oe;
  wire sda = ~(sda_oe | mdl_oe);
  spsq_host_seq #(.RAIL_GAP_CYC(GAP), .RST_HOLD_CYC(HOLD), .INIT_REF_CLKS(INIT),
    .PLL_LOCK_CYC(LOCK), .OFF_WAIT_CYC(OFFW), .REF_HALF_CYC(2), .TWI_QTR_CYC(2)
  ) u_spsq_host_seq (.i_core_clk(clk), .i_rst_b(rst_b), .i_power_up(pwr_up),
    .i_power_down(pwr_dn), .i_cfg_valid(cfg_valid), .i_cfg_wr(cfg_wr), .o_cfg_ready(cfg_ready),
    .i_cfg_done(cfg_done), .i_clk_dly(clk_dly), .i_data_dly(data_dly), .i_standby_seen(standby),
    .o_dly_bad(dly_bad), .o_streaming(streaming), .o_powered_off(powered_off), .o_nack(nack),
    .o_rails(rails), .o_ref_clk(ref_clk), .o_reset_b(reset_b), .i_scl(scl), .o_scl(scl_drv),
    .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(sda_drv), .o_sda_oe(sda_oe));
  spsq_sensor_model #(.INIT_CLKS(INIT)) u_spsq_sensor_model (.i_rails(rails),
    .i_reset_b(reset_b), .i_ref_clk(ref_clk), .i_scl(scl), .i_sda(sda), .i_nack_mode(nack_mode),
    .o_sda_oe(mdl_oe), .o_pix_oe(pix_oe), .o_standby(standby), .o_run_ctrl(run_ctrl),
    .o_last_wr(last_wr), .o_early(early));
  // ----
  // Helpers
  // ----
  initial forever #2 clk = ~clk;
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_for(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 3000) begin
      @(negedge clk);
      c++;
    end
    if (c == 3000) miscompares++;
  endtask
  task automatic cfg_write(input logic [15:0] a, input logic [15:0] d);
    wait_for(cfg_ready, 1'b1, n);
    cfg_wr = {a, d};
    cfg_valid = 1'b1;
    tick(1);
    cfg_valid = 1'b0;
    wait_for(cfg_ready, 1'b1, n);
  endtask
  task automatic pwr_on;
    pwr_up = 1'b1;
    tick(1);
    pwr_up = 1'b0;
    tick(1);
    for (int i = 1; i <= 5; i++) begin
      `CHK(rails, 5'((1 << i) - 1))
      `CHK(ref_clk, 1'b0)
      tick(GAP);
    end
    `CHK(pix_oe, 1'b0)
    wait_for(cfg_ready, 1'b1, n);
    `CHK(n >= HOLD + 4 * (INIT - 1), 1'b1)
    `CHK(early, 0)
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_boot;
    `CHK(rails, 5'h00)
    `CHK({scl_drv, sda_drv, scl_oe, sda_oe}, 4'h0)
    wait_for(powered_off, 1'b1, n);
    `CHK(n >= OFFW - 1, 1'b1)
    `CHK(reset_b, 1'b0)
    $display("boot done");
  endtask
  task automatic t_config;
    pwr_on;
    cfg_write(16'h3040, 16'hA5C3);
    `CHK(last_wr, 32'h3040A5C3)
    `CHK(nack, 1'b0)
    cfg_write(16'h301A, 16'h0010);
    `CHK(run_ctrl, 16'h0010)
    `CHK(streaming, 1'b0)
    $display("config done");
  endtask
  task automatic t_delays;
    for (int v = 0; v < 8; v++) begin
      clk_dly = 3'(v);
      tick(2);
      `CHK(dly_bad, v >= 6)
    end
    clk_dly = 3'h1;
    for (int v = 0; v < 8; v++) begin
      data_dly = 3'(v);
      tick(2);
      `CHK(dly_bad, (v == 3 || v == 5 || v == 7))
    end
    cfg_done = 1'b1;
    tick(LOCK + 20);
    cfg_done = 1'b0;
    `CHK(streaming, 1'b0)
    `CHK(cfg_ready, 1'b1)
    data_dly = 3'h2;
    $display("delays done");
  endtask
  task automatic t_stream;
    tick(2);
    cfg_done = 1'b1;
    tick(1);
    cfg_done = 1'b0;
    tick(LOCK - 1);
    `CHK(sda_oe, 1'b0)
    wait_for(streaming, 1'b1, n);
    `CHK(n > LOCK, 1'b1)
    `CHK(run_ctrl, 16'h0014)
    tick(40);
    `CHK(standby, 1'b0)
    $display("stream done");
  endtask
  task automatic t_power_down;
    pwr_dn = 1'b1;
    tick(1);
    pwr_dn = 1'b0;
    wait_for(standby, 1'b1, n);
    `CHK(run_ctrl, 16'h0010)
    `CHK(rails, 5'h1F)
    wait_for(reset_b, 1'b0, n);
    for (int i = 1; i <= 5; i++) begin
      tick(GAP);
      `CHK(rails, 5'h1F >> i)
    end
    wait_for(powered_off, 1'b1, n);
    `CHK(n >= OFFW - 1, 1'b1)
    $display("power down done");
  endtask
  task automatic t_nack;
    pwr_on;
    nack_mode = 1'b1;
    cfg_write(16'h3040, 16'h0001);
    nack_mode = 1'b0;
    `CHK(nack, 1'b1)
    pwr_dn = 1'b1;
    tick(1);
    pwr_dn = 1'b0;
    wait_for(powered_off, 1'b1, n);
    `CHK(rails, 5'h00)
    `CHK(n > 5 * GAP, 1'b1)
    $display("nack done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    t_boot;
    t_config;
    t_delays;
    t_stream;
    t_power_down;
    t_nack;
    tally_and_finish;
  end
  // Whole run needs a few thousand cycles; this leaves ample margin
  initial begin
    repeat (20000) @(negedge clk);
    miscompares++;
    tally_and_finish;
  end
endmodule
bind spsq_host_seq spsq_host_seq_props #(.RAIL_GAP_CYC(RAIL_GAP_CYC),
  .RST_HOLD_CYC(RST_HOLD_CYC), .INIT_REF_CLKS(INIT_REF_CLKS), .PLL_LOCK_CYC(PLL_LOCK_CYC),
  .OFF_WAIT_CYC(OFF_WAIT_CYC)) u_spsq_host_seq_props (.i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b), .i_clk_dly(i_clk_dly), .i_data_dly(i_data_dly), .o_cfg_ready(o_cfg_ready),
  .o_dly_bad(o_dly_bad), .o_streaming(o_streaming), .o_rails(o_rails), .o_ref_clk(o_ref_clk),
  .o_reset_b(o_reset_b), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe));
